// ==== hw/pbmc_mode_ctrl.sv ====
`timescale 1ns/1ps
`include "pbmc_defs.svh"
// Operation
// - reset sets fetch strobe enable
// - enable drives strobe on fetch, acks
// - enable: return opcode fetched once, fast
// - disabled: no strobe, return opcode refetched
// - one-shot bit reads one, resets one
// - writing zero strobes next fetch once
// - timing select resets one, alternate timing
// - select zero: io strobes at T2 rise
// - halt pin high in normal run
// - halt: refetch, all three pins low
// - halt keeps clocks, refresh, DMA running
// - halt exits on reset or interrupt
// - sleep entered when stop bits clear
// - sleep gates core and DMA clocks
// - sleep holds bus outputs high unless bus granted, halt low
// - sleep keeps serial and timers running
// - enabled interrupts wake from sleep
// - global enable set: service interrupt
// - global enable clear: just continue
// - resume 2 clocks after wake (15 ns rounded up to whole clocks)
// - peripheral stop halts serial and timers
// - sleep with stop gives system stop
// - status pins encode sleep and halt
module pbmc_mode_ctrl (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire pbmc_pkg::pbmc_cycle_t i_cycle,
  input wire logic i_halt_exec,
  input wire logic i_sleep_exec,
  input wire logic i_peripheral_stop,
  input wire logic [7:0] i_cpu_control,
  input wire logic i_global_int_enable,
  input wire logic i_onchip_int,
  input wire logic i_nmi_req,
  input wire logic i_maskable_int_req,
  input wire logic i_bus_granted,
  output logic [7:0] o_reg_rdata,
  output pbmc_pkg::pbmc_pins_t o_pins,
  output logic o_bus_idle_high,
  output logic o_core_clk_en,
  output logic o_dma_clk_en,
  output logic o_refresh_en,
  output logic o_periph_clk_en,
  output logic o_sysclk_out_en,
  output logic o_int_service,
  output logic o_return_from_interrupt_opcode_refetch
);
  logic rst_meta_q, rst_sync_q;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // wake sources are asynchronous to this block; two stages before use
  logic [2:0] wk_meta_q, wk_sync_q;
  always_ff @(posedge i_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      wk_meta_q <= 3'h0;
      wk_sync_q <= 3'h0;
    end else begin
      wk_meta_q <= {i_onchip_int, i_nmi_req, i_maskable_int_req};
      wk_sync_q <= wk_meta_q;
    end
  end

  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == `PBMC_OMR_ADDR);
  endfunction : reg_hit

  logic fse_q, fse_d, fos_pend_q, fos_pend_d, iots_q, iots_d;
  logic [7:0] rdata_q, rdata_d;
  pbmc_pkg::pbmc_state_t st_q, st_d;
  logic [`PBMC_WAKE_W-1:0] wcnt_q, wcnt_d;
  logic sysstop_q, sysstop_d, svc_q, svc_d, refetch_q, refetch_d;
  pbmc_pkg::pbmc_pins_t pins_d, pins_q;
  logic idle_d, idle_q, core_d, core_q, dma_d, dma_q, rfsh_d, rfsh_q, per_d, per_q;
  logic wake;

  always_comb begin
    fse_d = fse_q;
    iots_d = iots_q;
    fos_pend_d = fos_pend_q;
    rdata_d = 8'h00;
    if (i_cycle.fetch && fos_pend_q) begin
      fos_pend_d = 1'b0;
    end
    if (i_reg_wr && reg_hit(i_reg_addr)) begin
      fse_d = i_reg_wdata[`PBMC_BIT_FSE];
      iots_d = i_reg_wdata[`PBMC_BIT_IOTS];
      // zero arms the one-shot, one leaves things alone
      if (!i_reg_wdata[`PBMC_BIT_FOS]) begin
        fos_pend_d = 1'b1;
      end
    end
    if (i_reg_rd && reg_hit(i_reg_addr)) begin
      rdata_d[`PBMC_BIT_FSE] = fse_q;
      rdata_d[`PBMC_BIT_FOS] = 1'b1;
      rdata_d[`PBMC_BIT_IOTS] = iots_q;
    end
  end

  always_ff @(posedge i_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      fse_q <= 1'b1;
      fos_pend_q <= 1'b0;
      iots_q <= 1'b1;
      rdata_q <= 8'h00;
    end else begin
      fse_q <= fse_d;
      fos_pend_q <= fos_pend_d;
      iots_q <= iots_d;
      rdata_q <= rdata_d;
    end
  end

  // under system stop the on-chip sources are frozen and cannot wake
  assign wake = wk_sync_q[1] | wk_sync_q[0] | (wk_sync_q[2] & ~sysstop_q);

  always_comb begin
    st_d = st_q;
    wcnt_d = wcnt_q;
    sysstop_d = sysstop_q;
    svc_d = 1'b0;
    refetch_d = 1'b0;
    case (st_q)
      pbmc_pkg::PBMC_RUN: begin
        if (i_sleep_exec && !i_cpu_control[`PBMC_CCR_SLP_A]
            && !i_cpu_control[`PBMC_CCR_SLP_B]) begin
          st_d = pbmc_pkg::PBMC_SLEEP;
          sysstop_d = i_peripheral_stop;
        end else if (i_halt_exec) begin
          st_d = pbmc_pkg::PBMC_HALT;
        end
        if (i_cycle.return_from_interrupt_opcode_fetch && !fse_q) begin
          refetch_d = 1'b1;
        end
      end
      pbmc_pkg::PBMC_HALT: begin
        if (wake) begin
          st_d = pbmc_pkg::PBMC_RUN;
          svc_d = 1'b1;
        end
      end
      pbmc_pkg::PBMC_SLEEP: begin
        if (wake) begin
          st_d = pbmc_pkg::PBMC_WAKE;
          wcnt_d = `PBMC_WAKE_W'(`PBMC_WAKE_CYCLES);
        end
      end
      pbmc_pkg::PBMC_WAKE: begin
        wcnt_d = wcnt_q - `PBMC_WAKE_W'(1);
        if (wcnt_q == `PBMC_WAKE_W'(1)) begin
          st_d = pbmc_pkg::PBMC_RUN;
          sysstop_d = 1'b0;
          svc_d = i_global_int_enable;
        end
      end
      default: st_d = pbmc_pkg::PBMC_RUN;
    endcase
  end

  always_comb begin
    pins_d.halt_n = 1'b1;
    pins_d.cycle_status = 1'b0;
    pins_d.fetch_strobe_n = 1'b1;
    pins_d.io_request_strobe_n = 1'b1;
    pins_d.read_strobe_n = 1'b1;
    idle_d = 1'b0;
    core_d = 1'b1;
    dma_d = 1'b1;
    rfsh_d = 1'b1;
    per_d = !i_peripheral_stop;
    case (st_q)
      pbmc_pkg::PBMC_HALT: begin
        pins_d.halt_n = 1'b0;
        pins_d.fetch_strobe_n = 1'b0;
      end
      pbmc_pkg::PBMC_SLEEP, pbmc_pkg::PBMC_WAKE: begin
        pins_d.halt_n = 1'b0;
        pins_d.cycle_status = 1'b1;
        idle_d = !i_bus_granted;
        core_d = 1'b0;
        dma_d = 1'b0;
        rfsh_d = 1'b0;
        per_d = !sysstop_q && !i_peripheral_stop;
      end
      default: begin
        if ((i_cycle.fetch && (fse_q || fos_pend_q))
            || (fse_q && (i_cycle.maskable_interrupt_inputs_ack || i_cycle.nmi_ack_first))
            || (i_cycle.return_from_interrupt_opcode_fetch && fse_q)) begin
          pins_d.fetch_strobe_n = 1'b0;
        end
        if (refetch_q) begin
          pins_d.fetch_strobe_n = 1'b0;
        end
        if (i_cycle.io_cycle && (iots_q || i_cycle.t2_rise)) begin
          pins_d.io_request_strobe_n = 1'b0;
          pins_d.read_strobe_n = !i_cycle.io_read;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      st_q <= pbmc_pkg::PBMC_RUN;
      wcnt_q <= '0;
      sysstop_q <= 1'b0;
      svc_q <= 1'b0;
      refetch_q <= 1'b0;
      pins_q <= '1;
      idle_q <= 1'b0;
      core_q <= 1'b1;
      dma_q <= 1'b1;
      rfsh_q <= 1'b1;
      per_q <= 1'b1;
    end else begin
      st_q <= st_d;
      wcnt_q <= wcnt_d;
      sysstop_q <= sysstop_d;
      svc_q <= svc_d;
      refetch_q <= refetch_d;
      pins_q <= pins_d;
      idle_q <= idle_d;
      core_q <= core_d;
      dma_q <= dma_d;
      rfsh_q <= rfsh_d;
      per_q <= per_d;
    end
  end

  assign o_reg_rdata = rdata_q;
  assign o_pins = pins_q;
  assign o_bus_idle_high = idle_q;
  assign o_core_clk_en = core_q;
  assign o_dma_clk_en = dma_q;
  assign o_refresh_en = rfsh_q;
  assign o_periph_clk_en = per_q;
  assign o_sysclk_out_en = rst_sync_q;
  assign o_int_service = svc_q;
  assign o_return_from_interrupt_opcode_refetch = refetch_q;

  halt_pins_a: assert property (@(posedge i_clk) disable iff (!rst_sync_q)
    st_q == pbmc_pkg::PBMC_HALT |=> (!o_pins.halt_n && !o_pins.fetch_strobe_n
    && !o_pins.cycle_status)) else $error("halt status pins wrong");
  sleep_pins_a: assert property (@(posedge i_clk) disable iff (!rst_sync_q)
    st_q == pbmc_pkg::PBMC_SLEEP |=> (!o_pins.halt_n && o_pins.cycle_status
    && o_pins.fetch_strobe_n)) else $error("sleep status pins wrong");
  run_halt_a: assert property (@(posedge i_clk) disable iff (!rst_sync_q)
    st_q == pbmc_pkg::PBMC_RUN |=> o_pins.halt_n) else $error("halt pin low in run");
  sleep_entry_a: assert property (@(posedge i_clk) disable iff (!rst_sync_q)
    st_q == pbmc_pkg::PBMC_RUN && i_sleep_exec && !i_cpu_control[`PBMC_CCR_SLP_A]
    && !i_cpu_control[`PBMC_CCR_SLP_B] |=> st_q == pbmc_pkg::PBMC_SLEEP)
    else $error("sleep not entered");
  wake_time_a: assert property (@(posedge i_clk) disable iff (!rst_sync_q)
    st_q == pbmc_pkg::PBMC_SLEEP && wake |=> ##2 st_q == pbmc_pkg::PBMC_RUN)
    else $error("wake latency wrong");
  one_shot_a: assert property (@(posedge i_clk) disable iff (!rst_sync_q)
    fos_pend_q && i_cycle.fetch && st_q == pbmc_pkg::PBMC_RUN && !i_reg_wr
    |=> !o_pins.fetch_strobe_n && !fos_pend_q)
    else $error("one-shot strobe missing");
  read_one_a: assert property (@(posedge i_clk) disable iff (!rst_sync_q)
    i_reg_rd && reg_hit(i_reg_addr) |=> o_reg_rdata[`PBMC_BIT_FOS])
    else $error("one-shot read zero");
  sleep_clk_a: assert property (@(posedge i_clk) disable iff (!rst_sync_q)
    st_q == pbmc_pkg::PBMC_SLEEP |=> !o_core_clk_en && !o_dma_clk_en && !o_refresh_en)
    else $error("sleep clocks not gated");
  nomask_a: assert property (@(posedge i_clk) disable iff (!rst_sync_q)
    st_q == pbmc_pkg::PBMC_RUN && !fse_q && !fos_pend_q && !refetch_q && i_cycle.fetch
    && !i_cycle.return_from_interrupt_opcode_fetch |=> o_pins.fetch_strobe_n) else $error("strobe while disabled");
  halt_c: cover property (@(posedge i_clk) st_q == pbmc_pkg::PBMC_HALT ##1
    st_q == pbmc_pkg::PBMC_RUN);
  sleep_c: cover property (@(posedge i_clk) st_q == pbmc_pkg::PBMC_WAKE ##1
    st_q == pbmc_pkg::PBMC_RUN);
  stop_c: cover property (@(posedge i_clk) sysstop_q && st_q == pbmc_pkg::PBMC_SLEEP);
endmodule : pbmc_mode_ctrl

// ==== hw/pbmc_defs.svh ====
`ifndef PBMC_DEFS_SVH
`define PBMC_DEFS_SVH
`define PBMC_OMR_ADDR 8'h3e
`define PBMC_BIT_FSE 7
`define PBMC_BIT_FOS 6
`define PBMC_BIT_IOTS 5
`define PBMC_WAKE_HALF_CLOCKS 3
`define PBMC_CLK_PERIOD_NS 10
`define PBMC_WAKE_NS 15
`define PBMC_WAKE_CYCLES ((`PBMC_WAKE_NS + `PBMC_CLK_PERIOD_NS - 1) / `PBMC_CLK_PERIOD_NS)
`define PBMC_WAKE_W 2
`define PBMC_CCR_SLP_A 3
`define PBMC_CCR_SLP_B 6
`endif

// ==== hw/pbmc_pkg.sv ====
package pbmc_pkg;
  typedef enum logic [3:0] {
    PBMC_RUN = 4'h1,
    PBMC_HALT = 4'h2,
    PBMC_SLEEP = 4'h4,
    PBMC_WAKE = 4'h8
  } pbmc_state_t;

  typedef struct packed {
    logic fetch;
    logic maskable_interrupt_inputs_ack;
    logic nmi_ack_first;
    logic return_from_interrupt_opcode_fetch;
    logic io_cycle;
    logic io_read;
    logic t2_rise;
  } pbmc_cycle_t;

  typedef struct packed {
    logic fetch_strobe_n;
    logic halt_n;
    logic cycle_status;
    logic io_request_strobe_n;
    logic read_strobe_n;
  } pbmc_pins_t;
endpackage : pbmc_pkg

// ==== testbench/pbmc_bus_peer.sv ====
`timescale 1ns/1ps
// peripheral on the processor bus: counts first-cycle strobes it sees outside halt,
// as a legacy peripheral would when it decodes instruction fetches
module pbmc_bus_peer (
  input wire logic i_clk,
  input wire pbmc_pkg::pbmc_pins_t i_pins,
  output int o_strobes
);
  int count_q = 0;
  assign o_strobes = count_q;
  always @(posedge i_clk) begin
    if (i_pins.fetch_strobe_n === 1'b0 && i_pins.halt_n === 1'b1) begin
      count_q <= count_q + 1;
    end
  end
endmodule : pbmc_bus_peer

// ==== testbench/pbmc_mode_ctrl_tb.sv ====
`timescale 1ns/1ps
module pbmc_mode_ctrl_tb;
  logic i_clk, i_reset_n, i_reg_wr, i_reg_rd, i_halt_exec, i_sleep_exec, i_peripheral_stop;
  logic i_global_int_enable, i_onchip_int, i_nmi_req, i_maskable_int_req, i_bus_granted;
  logic [7:0] i_reg_addr, i_reg_wdata, i_cpu_control, o_reg_rdata, v;
  logic o_bus_idle_high, o_core_clk_en, o_dma_clk_en, o_refresh_en, o_periph_clk_en;
  logic o_sysclk_out_en, o_int_service, o_return_from_interrupt_opcode_refetch, l, svc, rf;
  pbmc_pkg::pbmc_cycle_t i_cycle;
  pbmc_pkg::pbmc_pins_t o_pins;
  int errors = 0, total_checks = 0, strobes, s0;
  pbmc_mode_ctrl i_dut (.i_clk, .i_reset_n, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata,
    .i_cycle, .i_halt_exec, .i_sleep_exec, .i_peripheral_stop, .i_cpu_control,
    .i_global_int_enable, .i_onchip_int, .i_nmi_req, .i_maskable_int_req, .i_bus_granted,
    .o_reg_rdata, .o_pins, .o_bus_idle_high, .o_core_clk_en, .o_dma_clk_en, .o_refresh_en,
    .o_periph_clk_en, .o_sysclk_out_en, .o_int_service, .o_return_from_interrupt_opcode_refetch);
  pbmc_bus_peer i_peer (.i_clk(i_clk), .i_pins(o_pins), .o_strobes(strobes));
  always #5 i_clk = ~i_clk;
  // sticky so a one-cycle pulse is never missed between samples
  always @(posedge i_clk) begin
    if (o_int_service === 1'b1) svc <= 1'b1;
    if (o_return_from_interrupt_opcode_refetch === 1'b1) rf <= 1'b1;
  end
  task chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task end_of_test;
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_of_test
  task tick(input int n);
    repeat (n) @(negedge i_clk);
  endtask : tick
  task reg_wr(input logic [7:0] d);
    i_reg_addr = 8'h3e; i_reg_wdata = d; i_reg_wr = 1'b1; tick(1); i_reg_wr = 1'b0;
  endtask : reg_wr
  // registered answer stands only in the cycle right after the request
  task reg_rd(input logic [7:0] a);
    i_reg_addr = a; i_reg_rd = 1'b1; tick(1); i_reg_rd = 1'b0;
    v = o_reg_rdata; tick(1);
  endtask : reg_rd
  task fetch;
    i_cycle.fetch = 1'b1; tick(1); i_cycle.fetch = 1'b0;
    l = (o_pins.fetch_strobe_n === 1'b0); tick(1);
  endtask : fetch
  task automatic pulse(ref logic s);
    s = 1'b1; tick(1); s = 1'b0;
  endtask : pulse
  task resume;
    for (int i = 0; i < 12; i++) begin
      if (o_pins.halt_n === 1'b1) return;
      tick(1);
    end
    errors++;
    $display("[FAIL] t=%0t got=%h exp=%h", $time, o_pins.halt_n, 1'b1);
    end_of_test;
  endtask : resume
  task t_reset;
    reg_rd(8'h3e); chk(v[7:5], 3'h7);
    reg_rd(8'h10); chk(v, 8'h00);
    chk(o_pins.halt_n, 1'b1);
    $display("reset test done");
  endtask : t_reset
  task t_strobe;
    fetch; chk(l, 1'b1);
    reg_wr(8'h00); s0 = strobes;
    reg_rd(8'h3e); chk(v[7:5], 3'h2);
    fetch; chk(l, 1'b1);
    fetch; chk(l, 1'b0);
    chk(strobes - s0, 8'h01);
    rf = 1'b0; i_cycle.return_from_interrupt_opcode_fetch = 1'b1; tick(1); i_cycle.return_from_interrupt_opcode_fetch = 1'b0;
    chk(o_pins.fetch_strobe_n, 1'b1);
    tick(1); chk(o_pins.fetch_strobe_n, 1'b0);
    tick(2); chk(rf, 1'b1);
    reg_wr(8'he0); rf = 1'b0;
    i_cycle.return_from_interrupt_opcode_fetch = 1'b1; tick(1); i_cycle.return_from_interrupt_opcode_fetch = 1'b0;
    chk(o_pins.fetch_strobe_n, 1'b0);
    tick(1); chk(o_pins.fetch_strobe_n, 1'b1);
    tick(2); chk(rf, 1'b0);
    $display("strobe test done");
  endtask : t_strobe
  task t_io;
    i_cycle.maskable_interrupt_inputs_ack = 1'b1; tick(1); i_cycle.maskable_interrupt_inputs_ack = 1'b0;
    chk(o_pins.fetch_strobe_n, 1'b0);
    i_cycle.nmi_ack_first = 1'b1; tick(1); i_cycle.nmi_ack_first = 1'b0;
    chk(o_pins.fetch_strobe_n, 1'b0);
    i_cycle.io_cycle = 1'b1; i_cycle.io_read = 1'b1; tick(1); i_cycle.io_read = 1'b0;
    chk({o_pins.io_request_strobe_n, o_pins.read_strobe_n}, 2'h0);
    tick(1); chk({o_pins.io_request_strobe_n, o_pins.read_strobe_n}, 2'h1);
    i_cycle.io_cycle = 1'b0; reg_wr(8'h40);
    i_cycle.io_cycle = 1'b1; i_cycle.io_read = 1'b1; tick(1);
    chk({o_pins.io_request_strobe_n, o_pins.read_strobe_n}, 2'h3);
    i_cycle.t2_rise = 1'b1; tick(1);
    chk({o_pins.io_request_strobe_n, o_pins.read_strobe_n}, 2'h0);
    // a reset in mid-run must bring the mode bits back to their defaults
    i_cycle = '0; i_reset_n = 1'b0; tick(2); i_reset_n = 1'b1; tick(3);
    reg_rd(8'h3e); chk(v[7:5], 3'h7);
    $display("io test done");
  endtask : t_io
  task t_halt;
    pulse(i_halt_exec); tick(2);
    chk({o_pins.fetch_strobe_n, o_pins.halt_n, o_pins.cycle_status}, 3'h0);
    chk({o_core_clk_en, o_dma_clk_en, o_refresh_en, o_periph_clk_en}, 4'hf);
    svc = 1'b0; i_nmi_req = 1'b1; resume; tick(1); chk(svc, 1'b1);
    i_nmi_req = 1'b0; tick(2);
    $display("halt test done");
  endtask : t_halt
  task t_sleep(input logic gie);
    i_global_int_enable = gie; pulse(i_sleep_exec); tick(3);
    chk({o_pins.fetch_strobe_n, o_pins.halt_n, o_pins.cycle_status}, 3'h5);
    chk(o_bus_idle_high, 1'b1);
    chk({o_core_clk_en, o_dma_clk_en, o_refresh_en, o_periph_clk_en}, 4'h1);
    i_bus_granted = 1'b1; tick(2); chk(o_bus_idle_high, 1'b0);
    i_bus_granted = 1'b0; svc = 1'b0; i_maskable_int_req = 1'b1;
    resume; tick(1); chk(svc, gie);
    chk(o_core_clk_en, 1'b1);
    i_maskable_int_req = 1'b0; tick(2);
    $display("sleep test done");
  endtask : t_sleep
  task t_stop;
    i_cpu_control = 8'h08; pulse(i_sleep_exec); tick(3);
    chk(o_pins.halt_n, 1'b1);
    i_cpu_control = 8'h00; i_peripheral_stop = 1'b1; tick(2);
    chk({o_core_clk_en, o_periph_clk_en}, 2'h2);
    pulse(i_sleep_exec); tick(3);
    chk({o_core_clk_en, o_periph_clk_en, o_sysclk_out_en}, 3'h1);
    i_onchip_int = 1'b1; tick(8); chk(o_pins.halt_n, 1'b0);
    i_onchip_int = 1'b0; i_nmi_req = 1'b1; resume;
    i_nmi_req = 1'b0; i_peripheral_stop = 1'b0; tick(2);
    chk(o_periph_clk_en, 1'b1);
    $display("stop test done");
  endtask : t_stop
  initial begin
    i_clk = 1'b0; i_reset_n = 1'b0; i_reg_wr = 1'b0; i_reg_rd = 1'b0;
    i_reg_addr = 8'h00; i_reg_wdata = 8'h00; i_cycle = '0; i_halt_exec = 1'b0;
    i_sleep_exec = 1'b0; i_peripheral_stop = 1'b0; i_cpu_control = 8'h00;
    i_global_int_enable = 1'b0; i_onchip_int = 1'b0; i_nmi_req = 1'b0;
    i_maskable_int_req = 1'b0; i_bus_granted = 1'b0; svc = 1'b0; rf = 1'b0;
    tick(4); i_reset_n = 1'b1; tick(3);
    t_reset;
    t_strobe;
    t_io;
    t_halt;
    t_sleep(1'b1);
    t_sleep(1'b0);
    t_stop;
    end_of_test;
  end
endmodule : pbmc_mode_ctrl_tb
